/* design/wdw_pkg.sv */
package wdw_pkg;
   localparam logic [11:0] WD_PERIOD_ENABLE_CONTROL_OFS = 12'h080C;
   localparam logic [11:0] WD_CLOCK_WINDOW_CONTROL_OFS = 12'h080D;
   localparam logic [11:0] WD_PRESCALE_COUNT_LOW_OFS = 12'h080E;
   localparam logic [11:0] WD_PRESCALE_COUNT_HIGH_OFS = 12'h080F;
   localparam logic [11:0] WD_TIMER_STATUS_OFS = 12'h0810;
   localparam logic [11:0] WD_CLEAR_OFS = 12'h0811;
   localparam logic [7:0] WD_CLEAR_KEY = 8'h5A;
   localparam logic [7:0] CON0_RESET = 8'h00;
   localparam logic [7:0] CON1_RESET = 8'h07;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int PRESCALE_WIDTH = 18;
   localparam int COUNTER_WIDTH = 5;
   localparam int PERIOD_POS = 3;
   localparam int ENABLE_POS = 0;
   localparam int CLOCK_SEL_POS = 4;
   localparam int WINDOW_POS = 0;

   typedef enum logic [1:0] {
      WD_IDLE = 2'b00,
      WD_ARMED = 2'b01,
      WD_FIRED = 2'b11
   } wdw_state_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [7:0] datW;
   } wdw_bus_req_type;
endpackage

/* design/wdw_windowed_watchdog.sv */
`timescale 1ns/1ps
module wdw_windowed_watchdog (
   input wire logic clk,
   input wire logic reset,
   input wire wdw_pkg::wdw_bus_req_type busReq,
   input wire logic [0:0] busSel,
   output logic [7:0] busDatR,
   output logic busAck,
   input wire logic [7:0] clockTicks,
   output logic wdResetPulse,
   output logic windowViolation
);
   import wdw_pkg::*;

   logic [7:0] con0_reg;
   logic [7:0] con1_reg;
   logic [PRESCALE_WIDTH-1:0] prescale_reg;
   logic [COUNTER_WIDTH-1:0] counter_reg;
   wdw_state_type state_reg;
   logic ack_reg;
   logic [7:0] datR_reg;
   logic [2:0] tickSync_reg;
   logic tickSeen_reg;
   logic wdReset_reg;
   logic violation_reg;

   logic [4:0] periodSelect;
   logic softwareEnable;
   logic [2:0] wdClockSelect;
   logic [2:0] windowSize;
   logic [COUNTER_WIDTH-1:0] openStart;
   logic windowOpen;
   logic busAccess;
   logic busWrite;
   logic clearWrite;
   logic tickEdge;
   logic periodHit;
   logic [PRESCALE_WIDTH-1:0] periodMask;
   logic [7:0] statusValue;
   logic [7:0] readValue;

   ////////////////////////////////////////////////////////////////////////////
   // field decode

   assign periodSelect = con0_reg[PERIOD_POS +: 5];
   assign softwareEnable = con0_reg[ENABLE_POS];
   assign wdClockSelect = con1_reg[CLOCK_SEL_POS +: 3];
   assign windowSize = con1_reg[WINDOW_POS +: 3];

   // open start is 4 * (7 - window); 111 yields zero, fully open
   assign openStart = {3'h7 - windowSize, 2'h0};
   assign windowOpen = (counter_reg >= openStart);

   assign statusValue = {counter_reg,
                         state_reg == WD_ARMED,
                         prescale_reg[17:16]};

   ////////////////////////////////////////////////////////////////////////////
   // bus slave

   assign busAccess = busReq.cyc && busReq.stb && !ack_reg;
   assign busWrite = busAccess && busReq.we && busSel[0];
   assign clearWrite = busWrite && busReq.adr == WD_CLEAR_OFS
                       && busReq.datW == WD_CLEAR_KEY;

   always_comb begin
      case (busReq.adr)
         WD_PERIOD_ENABLE_CONTROL_OFS: readValue = con0_reg;
         WD_CLOCK_WINDOW_CONTROL_OFS: readValue = con1_reg;
         WD_PRESCALE_COUNT_LOW_OFS: readValue = prescale_reg[7:0];
         WD_PRESCALE_COUNT_HIGH_OFS: readValue = prescale_reg[15:8];
         WD_TIMER_STATUS_OFS: readValue = statusValue;
         default: readValue = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= busAccess;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         datR_reg <= STATUS_RESET;
      end else if (busAccess && !busReq.we) begin
         datR_reg <= readValue;
      end
   end

   assign busAck = ack_reg;
   assign busDatR = datR_reg;

   // status and prescale bytes have no write path
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         con0_reg <= CON0_RESET;
         con1_reg <= CON1_RESET;
      end else if (busWrite) begin
         if (busReq.adr == WD_PERIOD_ENABLE_CONTROL_OFS) begin
            con0_reg <= busReq.datW;
         end
         if (busReq.adr == WD_CLOCK_WINDOW_CONTROL_OFS) begin
            con1_reg <= {1'b0, busReq.datW[6:4], 1'b0, busReq.datW[2:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog clock source select and synchroniser

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tickSync_reg <= 3'h0;
      end else begin
         tickSync_reg <= {tickSync_reg[1:0], clockTicks[wdClockSelect]};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tickSeen_reg <= 1'b0;
      end else if (tickSync_reg[2] == tickSync_reg[1]) begin
         tickSeen_reg <= tickSync_reg[2];
      end
   end

   assign tickEdge = (tickSync_reg[2] == tickSync_reg[1])
                     && tickSync_reg[2] && !tickSeen_reg;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler and window counter

   // period select n gives 2^(n+1) ticks, limited by the prescaler width
   always_comb begin
      periodMask = '0;
      for (int i = 0; i < PRESCALE_WIDTH; i++) begin
         periodMask[i] = (i <= int'(periodSelect));
      end
   end

   assign periodHit = tickEdge
                      && ((prescale_reg & periodMask) == periodMask);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prescale_reg <= '0;
      end else if (state_reg != WD_ARMED || clearWrite) begin
         prescale_reg <= '0;
      end else if (periodHit) begin
         prescale_reg <= '0;
      end else if (tickEdge) begin
         prescale_reg <= prescale_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         counter_reg <= '0;
      end else if (state_reg != WD_ARMED || clearWrite) begin
         counter_reg <= '0;
      end else if (periodHit) begin
         counter_reg <= counter_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arm state and watchdog reset

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= WD_IDLE;
         wdReset_reg <= 1'b0;
         violation_reg <= 1'b0;
      end else begin
         wdReset_reg <= 1'b0;
         violation_reg <= 1'b0;
         case (state_reg)
            WD_IDLE: begin
               if (softwareEnable) begin
                  state_reg <= WD_ARMED;
               end
            end
            WD_ARMED: begin
               if (!softwareEnable) begin
                  state_reg <= WD_IDLE;
               end else if (clearWrite && !windowOpen) begin
                  state_reg <= WD_FIRED;
                  wdReset_reg <= 1'b1;
                  violation_reg <= 1'b1;
               end else if (periodHit && &counter_reg && !clearWrite) begin
                  state_reg <= WD_FIRED;
                  wdReset_reg <= 1'b1;
               end
            end
            WD_FIRED: begin
               state_reg <= WD_IDLE;
            end
            default: begin
               state_reg <= WD_IDLE;
            end
         endcase
      end
   end

   assign wdResetPulse = wdReset_reg;
   assign windowViolation = violation_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_status_reset_zero: assert property (@(posedge clk)
      $fell(reset) |-> statusValue == STATUS_RESET)
      else $error("status not zero after reset");

   a_status_counter_field: assert property (@(posedge clk)
      disable iff (reset) statusValue[7:3] == counter_reg)
      else $error("status counter field wrong");

   a_full_open_window: assert property (@(posedge clk)
      disable iff (reset) windowSize == 3'h7 |-> windowOpen)
      else $error("window 111 not fully open");

   a_open_87_75: assert property (@(posedge clk)
      disable iff (reset)
      (windowSize == 3'h6 |-> windowOpen == (counter_reg >= 5'h04))
      and (windowSize == 3'h5 |-> windowOpen == (counter_reg >= 5'h08)))
      else $error("window 110 or 101 wrong");

   a_open_62_50: assert property (@(posedge clk)
      disable iff (reset)
      (windowSize == 3'h4 |-> windowOpen == (counter_reg >= 5'h0C))
      and (windowSize == 3'h3 |-> windowOpen == (counter_reg >= 5'h10)))
      else $error("window 100 or 011 wrong");

   a_open_low_settings: assert property (@(posedge clk)
      disable iff (reset)
      (windowSize == 3'h0 |-> windowOpen == (counter_reg >= 5'h1C))
      and (windowSize == 3'h1 |-> windowOpen == (counter_reg >= 5'h18)))
      else $error("window 000 or 001 wrong");

   a_armed_bit: assert property (@(posedge clk)
      disable iff (reset)
      $rose(softwareEnable) && state_reg == WD_IDLE
      |=> statusValue[2])
      else $error("armed bit not set after enable");

   a_prescale_upper: assert property (@(posedge clk)
      disable iff (reset) statusValue[1:0] == prescale_reg[17:16])
      else $error("prescale upper bits wrong");

   a_violation_reset: assert property (@(posedge clk)
      disable iff (reset)
      state_reg == WD_ARMED && softwareEnable && clearWrite && !windowOpen
      |=> wdResetPulse && windowViolation)
      else $error("closed window clear did not reset");

   a_expire_reset: assert property (@(posedge clk)
      disable iff (reset)
      state_reg == WD_ARMED && softwareEnable && !clearWrite
      && periodHit && &counter_reg |=> wdResetPulse ##1 !wdResetPulse)
      else $error("expiry reset wrong");

   a_ack_one_cycle: assert property (@(posedge clk)
      disable iff (reset) busAck |=> !busAck)
      else $error("ack longer than one cycle");

   a_ack_follows_request: assert property (@(posedge clk)
      disable iff (reset) busReq.cyc && busReq.stb && !busAck |=> busAck)
      else $error("request not acknowledged");

   a_con1_reserved_zero: assert property (@(posedge clk)
      disable iff (reset) !con1_reg[7] && !con1_reg[3])
      else $error("unused control bits set");

   a_read_status_data: assert property (@(posedge clk)
      disable iff (reset)
      busAccess && !busReq.we && busReq.adr == WD_TIMER_STATUS_OFS
      |=> busDatR == $past(statusValue))
      else $error("status read data wrong");

   a_read_low_data: assert property (@(posedge clk)
      disable iff (reset)
      busAccess && !busReq.we && busReq.adr == WD_PRESCALE_COUNT_LOW_OFS
      |=> busDatR == $past(prescale_reg[7:0]))
      else $error("prescale low read data wrong");

   a_clear_restarts: assert property (@(posedge clk)
      disable iff (reset)
      state_reg == WD_ARMED && softwareEnable && clearWrite && windowOpen
      |=> counter_reg == '0 && prescale_reg == '0 && !wdResetPulse)
      else $error("good clear did not restart counters");

   a_counter_step: assert property (@(posedge clk)
      disable iff (reset)
      state_reg == WD_ARMED && periodHit && !clearWrite && !(&counter_reg)
      |=> counter_reg == $past(counter_reg) + 1'b1)
      else $error("counter did not step on period");

   a_disable_disarms: assert property (@(posedge clk)
      disable iff (reset)
      state_reg == WD_ARMED && !softwareEnable |=> !statusValue[2])
      else $error("armed bit kept after disable");

   a_open_010: assert property (@(posedge clk)
      disable iff (reset)
      windowSize == 3'h2 |-> windowOpen == (counter_reg >= 5'h14))
      else $error("window 010 wrong");

   a_reset_one_cycle: assert property (@(posedge clk)
      disable iff (reset) wdResetPulse |=> !wdResetPulse)
      else $error("reset pulse longer than one cycle");

   a_violation_with_reset: assert property (@(posedge clk)
      disable iff (reset) windowViolation |-> wdResetPulse)
      else $error("violation without reset pulse");

   c_disarm: cover property (@(posedge clk) disable iff (reset)
      state_reg == WD_ARMED && !softwareEnable);

   c_arm: cover property (@(posedge clk) disable iff (reset)
      state_reg == WD_ARMED);
   c_expire: cover property (@(posedge clk) disable iff (reset)
      wdResetPulse && !windowViolation);
   c_violation: cover property (@(posedge clk) disable iff (reset)
      windowViolation);
   c_good_clear: cover property (@(posedge clk) disable iff (reset)
      clearWrite && windowOpen && state_reg == WD_ARMED);
endmodule

/* verification/windowed_watchdog_status_bench.sv */
`timescale 1ns/1ps
module windowed_watchdog_status_bench;
   import wdw_pkg::*;
   logic clk;
   logic reset;
   wdw_bus_req_type busReq;
   logic [0:0] busSel;
   logic [7:0] busDatR;
   logic busAck;
   logic [7:0] clockTicks;
   logic wdResetPulse;
   logic windowViolation;
   int failures = 0;
   int samples_checked = 0;
   int tickSel = 0;
   logic sawViol = 0;
   logic sawRst = 0;
   logic [7:0] rd;

   wdw_windowed_watchdog i_dut (.clk(clk), .reset(reset), .busReq(busReq),
      .busSel(busSel), .busDatR(busDatR), .busAck(busAck),
      .clockTicks(clockTicks), .wdResetPulse(wdResetPulse),
      .windowViolation(windowViolation));

   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (windowViolation === 1'b1) sawViol = 1;
      if (wdResetPulse === 1'b1) sawRst = 1;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // classic single cycle, held until ack is seen at a rising edge
   task automatic wb(input logic we, input logic [11:0] adr,
         input logic [7:0] dat);
      int n;
      n = 0;
      @(posedge clk);
      busReq <= {1'b1, 1'b1, we, adr, dat};
      busSel <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (busAck !== 1'b1 && n < 50);
      if (n >= 50) chk(8'h01, 8'h00);
      rd = busDatR;
      busReq <= '0;
      busSel <= 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         clockTicks <= 8'h01 << tickSel;
         repeat (6) @(posedge clk);
         clockTicks <= 8'h00;
         repeat (6) @(posedge clk);
      end
   endtask
   task automatic arm(input logic [7:0] con1);
      wb(1, WD_PERIOD_ENABLE_CONTROL_OFS, 8'h00);
      wb(1, WD_CLOCK_WINDOW_CONTROL_OFS, con1);
      wb(1, WD_PERIOD_ENABLE_CONTROL_OFS, 8'h01);
      sawViol = 0;
      sawRst = 0;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic test_regs;
      wb(0, WD_PERIOD_ENABLE_CONTROL_OFS, 0); chk(rd, 8'h00);
      wb(0, WD_CLOCK_WINDOW_CONTROL_OFS, 0); chk(rd, 8'h07);
      wb(0, WD_PRESCALE_COUNT_LOW_OFS, 0); chk(rd, 8'h00);
      wb(0, WD_TIMER_STATUS_OFS, 0); chk(rd, 8'h00);
      wb(1, WD_PERIOD_ENABLE_CONTROL_OFS, 8'hF8);
      wb(0, WD_PERIOD_ENABLE_CONTROL_OFS, 0); chk(rd, 8'hF8);
      wb(1, WD_CLOCK_WINDOW_CONTROL_OFS, 8'hFF);
      wb(0, WD_CLOCK_WINDOW_CONTROL_OFS, 0); chk(rd, 8'h77);
      for (int a = 'h80E; a <= 'h810; a++) begin
         wb(1, a[11:0], 8'hFF);
         wb(0, a[11:0], 0); chk(rd, 8'h00);
      end
      wb(0, 12'h0812, 0); chk(rd, 8'h00);
      arm(8'h37);
      wb(0, WD_TIMER_STATUS_OFS, 0); chk(rd, 8'h04);
      tickSel = 0;
      tick(1);
      wb(0, WD_PRESCALE_COUNT_LOW_OFS, 0); chk(rd, 8'h00);
      tickSel = 3;
      tick(1);
      wb(0, WD_PRESCALE_COUNT_LOW_OFS, 0); chk(rd, 8'h01);
      wb(0, WD_PRESCALE_COUNT_HIGH_OFS, 0); chk(rd, 8'h00);
      tickSel = 0;
      $display("register test done");
   endtask
   // step the counter to n, then clear: closed range must trip
   task automatic run_win(input int w, input int n);
      logic expV;
      expV = (n < 4 * (7 - w));
      arm(w[7:0]);
      tick(2 * n);
      wb(0, WD_TIMER_STATUS_OFS, 0); chk(rd, {n[4:0], 3'b100});
      wb(1, WD_CLEAR_OFS, WD_CLEAR_KEY);
      repeat (3) @(posedge clk);
      chk({7'd0, sawViol}, {7'd0, expV});
      chk({7'd0, sawRst}, {7'd0, expV});
   endtask
   task automatic test_windows;
      int thr;
      for (int w = 0; w < 8; w++) begin
         thr = 4 * (7 - w);
         if (thr > 0) run_win(w, thr - 1);
         run_win(w, thr);
      end
      $display("window test done");
   endtask
   task automatic test_expiry;
      arm(8'h07);
      tick(63);
      chk({7'd0, sawRst}, 8'h00);
      tick(1);
      chk({7'd0, sawRst}, 8'h01);
      chk({7'd0, sawViol}, 8'h00);
      $display("expiry test done");
   endtask
   task automatic test_midreset;
      arm(8'h07);
      tick(4);
      @(posedge clk);
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      wb(0, WD_TIMER_STATUS_OFS, 0); chk(rd, 8'h00);
      wb(0, WD_PERIOD_ENABLE_CONTROL_OFS, 0); chk(rd, 8'h00);
      $display("reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1;
      busReq = '0;
      busSel = 1'b0;
      clockTicks = 8'h00;
      repeat (12) @(posedge clk);
      reset <= 0;
      test_regs();
      test_windows();
      test_expiry();
      test_midreset();
      end_sim();
   end
   initial begin
      #(40 * 60000);
      failures++;
      end_sim();
   end
endmodule
